/* verilog/upstream_link_ctrl_status_regs.sv */
// Upstream link control and link status configuration registers
`timescale 1ns/1ps
module upstream_link_ctrl_status_regs #(
  parameter int   ADDR_W        = 10,
  parameter logic UNDEFINED_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Configuration access, dword addressed
  input  wire logic              cfgRdEn,
  input  wire logic              cfgWrEn,
  input  wire logic [ADDR_W-1:0] cfgDwAddr,
  input  wire logic [3:0]        cfgByteEn,
  input  wire logic [31:0]       cfgWrData,
  output logic      [31:0]       cfgRdData,
  output logic                   cfgRdValid,
  // Link power and clock controls
  output logic                   sharedRefclk,
  output logic                   l0sEnable,
  output logic                   l1Enable
);

  // The link dword index needs six address bits
  if (ADDR_W < 6) begin : gAddrTooNarrow
    $error("ADDR_W too small to reach the link registers");
  end

  localparam logic [ADDR_W-1:0] LINK_DW = ADDR_W'(link_regs_pkg::LINK_CTRL_OFFSET >> 2);

  link_ctrl_if ctl ();

  link_ctrl_store u_store (
    .clk (clk),
    .rst (rst),
    .ctl (ctl.store)
  );

  logic        hitLink;
  logic [15:0] ctrlWord;
  logic [15:0] statusWord;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic        rdValid_r;
  logic        rdValid_nxt;
  logic        sharedRefclk_r;
  logic        sharedRefclk_nxt;
  logic        l0sEnable_r;
  logic        l0sEnable_nxt;
  logic        l1Enable_r;
  logic        l1Enable_nxt;

  assign hitLink = (cfgDwAddr == LINK_DW);

  // Only byte lane 0 of the link dword holds writable bits
  assign ctl.wrLow  = cfgWrEn && hitLink && cfgByteEn[0];
  assign ctl.wrByte = cfgWrData[7:0];

  // Read views; constants ignore any write
  always_comb begin
    ctrlWord = link_regs_pkg::LINK_CTRL_RESET;
    ctrlWord[link_regs_pkg::SHARED_REFCLK_POS] = ctl.sharedRefclk;
    ctrlWord[link_regs_pkg::RETRAIN_POS]       = 1'b0;
    ctrlWord[link_regs_pkg::LINK_OFF_POS]      = 1'b0;
    ctrlWord[link_regs_pkg::COMPL_BOUND_POS]   = link_regs_pkg::COMPL_BOUND_64B;
    ctrlWord[link_regs_pkg::CTRL_RSVD_POS]     = 1'b0;
    ctrlWord[link_regs_pkg::PM_FIELD_LSB +: link_regs_pkg::PM_FIELD_W] = ctl.pmField;
  end

  always_comb begin
    statusWord = '0;
    statusWord[15:link_regs_pkg::STAT_RSVD_LSB]     = link_regs_pkg::STAT_RSVD_VALUE;
    statusWord[link_regs_pkg::SLOT_REFCLK_POS]      = link_regs_pkg::SLOT_REFCLK_VALUE;
    statusWord[link_regs_pkg::TRAINING_POS]         = link_regs_pkg::TRAINING_VALUE;
    statusWord[link_regs_pkg::UNDEFINED_POS]        = UNDEFINED_VAL;
    statusWord[link_regs_pkg::WIDTH_LSB +: 6]       = link_regs_pkg::WIDTH_X1;
    statusWord[link_regs_pkg::SPEED_LSB +: 4]       = link_regs_pkg::SPEED_2G5;
  end

  // Read answer one cycle after the request; unmapped reads return zero
  always_comb begin
    rdValid_nxt = cfgRdEn;
    rdData_nxt  = '0;
    if (cfgRdEn && hitLink) begin
      rdData_nxt = {statusWord, ctrlWord};
    end
  end

  // Power-management decode; the reserved code enables nothing
  always_comb begin
    sharedRefclk_nxt = ctl.sharedRefclk;
    l0sEnable_nxt    = 1'b0;
    l1Enable_nxt     = 1'b0;
    unique case (ctl.pmField)
      link_regs_pkg::PM_DISABLED: l0sEnable_nxt = 1'b0;
      link_regs_pkg::PM_L0S:      l0sEnable_nxt = 1'b1;
      link_regs_pkg::PM_RESERVED: l0sEnable_nxt = 1'b0;
      link_regs_pkg::PM_L0S_L1: begin
        l0sEnable_nxt = 1'b1;
        l1Enable_nxt  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r       <= '0;
      rdValid_r      <= 1'b0;
      sharedRefclk_r <= 1'b0;
      l0sEnable_r    <= 1'b0;
      l1Enable_r     <= 1'b0;
    end else begin
      rdData_r       <= rdData_nxt;
      rdValid_r      <= rdValid_nxt;
      sharedRefclk_r <= sharedRefclk_nxt;
      l0sEnable_r    <= l0sEnable_nxt;
      l1Enable_r     <= l1Enable_nxt;
    end
  end

  assign cfgRdData    = rdData_r;
  assign cfgRdValid   = rdValid_r;
  assign sharedRefclk = sharedRefclk_r;
  assign l0sEnable    = l0sEnable_r;
  assign l1Enable     = l1Enable_r;

  // Independent copy of the writable control bits for the checks below
  logic       shadowShared_r;
  logic       shadowShared_nxt;
  logic [1:0] shadowPm_r;
  logic [1:0] shadowPm_nxt;

  always_comb begin
    shadowShared_nxt = shadowShared_r;
    shadowPm_nxt     = shadowPm_r;
    if (cfgWrEn && hitLink && cfgByteEn[0]) begin
      shadowShared_nxt = cfgWrData[link_regs_pkg::SHARED_REFCLK_POS];
      shadowPm_nxt     = cfgWrData[link_regs_pkg::PM_FIELD_LSB +: link_regs_pkg::PM_FIELD_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shadowShared_r <= link_regs_pkg::LINK_CTRL_RESET[link_regs_pkg::SHARED_REFCLK_POS];
      shadowPm_r     <= link_regs_pkg::LINK_CTRL_RESET[link_regs_pkg::PM_FIELD_LSB +: link_regs_pkg::PM_FIELD_W];
    end else begin
      shadowShared_r <= shadowShared_nxt;
      shadowPm_r     <= shadowPm_nxt;
    end
  end

  // Checks
  sequence seqLinkRead;
    cfgRdEn && hitLink;
  endsequence

  sequence seqPmWrite;
    cfgWrEn && hitLink && cfgByteEn[0] && !cfgRdEn;
  endsequence

  sequence seqLinkReadOnly;
    cfgRdEn && hitLink && !cfgWrEn;
  endsequence

  sequence seqPmWriteNextRead;
    seqPmWrite ##1 seqLinkReadOnly;
  endsequence

  sequence seqPmWriteGapRead;
    seqPmWrite ##1 !cfgWrEn ##1 seqLinkReadOnly;
  endsequence

  sequence seqStatusWrite;
    cfgWrEn && hitLink && cfgByteEn[3:2] != 2'h0;
  endsequence

  chk_read_answer_latency: assert property (@(posedge clk) disable iff (rst)
    cfgRdEn |=> cfgRdValid)
    else $error("Read answer not one cycle after request");

  chk_status_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[31:29] == 3'h0)
    else $error("Status reserved bits not zero");

  chk_status_slot_clock: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[28] && !cfgRdData[27])
    else $error("Status clock or training bit wrong");

  chk_status_width_speed: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[25:20] == 6'h01 && cfgRdData[19:16] == 4'h1)
    else $error("Status width or speed wrong");

  chk_ctrl_fixed_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[5:2] == 4'h0)
    else $error("Control fixed bits not zero");

  chk_pm_write_read: assert property (@(posedge clk) disable iff (rst)
    seqPmWriteNextRead |=> cfgRdData[1:0] == $past(cfgWrData[1:0], 2))
    else $error("Power-management field did not keep written value");

  chk_pm_decode_l1: assert property (@(posedge clk) disable iff (rst)
    seqPmWrite ##2 1 |-> l1Enable == ($past(cfgWrData[1:0], 2) == 2'h3))
    else $error("L1 enable does not follow written field");

  chk_shared_clock_out: assert property (@(posedge clk) disable iff (rst)
    seqPmWrite ##2 1 |-> sharedRefclk == $past(cfgWrData[6], 2))
    else $error("Shared clock output does not follow flag");

  chk_status_write_ignored: assert property (@(posedge clk) disable iff (rst)
    seqStatusWrite ##1 seqLinkRead |=> (cfgRdData[28:16] & 13'h1BFF) == 13'h1011)
    else $error("Status changed after write");

  chk_idle_no_answer: assert property (@(posedge clk) disable iff (rst)
    !cfgRdEn |=> !cfgRdValid && cfgRdData == 32'h0000_0000)
    else $error("Answer without a read");

  chk_status_word_all: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[31:16] == {3'h0, 1'b1, 1'b0, UNDEFINED_VAL, 6'h01, 4'h1})
    else $error("Status word wrong");

  chk_status_training_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> !cfgRdData[27])
    else $error("Training bit not zero");

  chk_status_undefined_bit: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[26] == UNDEFINED_VAL)
    else $error("Undefined bit not the chosen value");

  chk_ctrl_retrain_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> !cfgRdData[5])
    else $error("Retrain bit not zero");

  chk_ctrl_link_off_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> !cfgRdData[4])
    else $error("Link off bit not zero");

  chk_ctrl_boundary_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> !cfgRdData[3])
    else $error("Completion boundary bit not zero");

  chk_ctrl_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> !cfgRdData[2])
    else $error("Reserved control bit not zero");

  chk_ctrl_upper_zero: assert property (@(posedge clk) disable iff (rst)
    seqLinkRead |=> cfgRdData[15:7] == 9'h000)
    else $error("Upper control bits not zero");

  chk_shared_flag_read: assert property (@(posedge clk) disable iff (rst)
    seqPmWriteNextRead |=> cfgRdData[6] == $past(cfgWrData[6], 2))
    else $error("Shared clock flag not read back");

  chk_shared_flag_gap: assert property (@(posedge clk) disable iff (rst)
    seqPmWriteGapRead |=> cfgRdData[6] == $past(cfgWrData[6], 3))
    else $error("Shared clock flag lost after a gap");

  chk_pm_write_gap: assert property (@(posedge clk) disable iff (rst)
    seqPmWriteGapRead |=> cfgRdData[1:0] == $past(cfgWrData[1:0], 3))
    else $error("Power-management field lost after a gap");

  chk_pm_decode_l0s: assert property (@(posedge clk) disable iff (rst)
    seqPmWrite ##2 1'b1 |-> l0sEnable == $past(cfgWrData[0], 2))
    else $error("L0s enable does not follow written field");

  chk_store_hold: assert property (@(posedge clk) disable iff (rst)
    !ctl.wrLow |=> $stable(ctl.pmField) && $stable(ctl.sharedRefclk))
    else $error("Control bits changed without a write");

  chk_reserved_code_idle: assert property (@(posedge clk) disable iff (rst)
    ctl.pmField == link_regs_pkg::PM_RESERVED |=> !l0sEnable && !l1Enable)
    else $error("Reserved code enabled a low-power state");

  chk_l1_needs_l0s: assert property (@(posedge clk) disable iff (rst)
    l1Enable |-> l0sEnable)
    else $error("L1 enabled without L0s");

  chk_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
    cfgRdEn && !hitLink |=> cfgRdData == 32'h0000_0000)
    else $error("Unmapped read not zero");

  chk_valid_needs_read: assert property (@(posedge clk) disable iff (rst)
    cfgRdValid |-> $past(cfgRdEn))
    else $error("Answer valid without a request");

  chk_shadow_pm: assert property (@(posedge clk) disable iff (rst)
    ctl.pmField == shadowPm_r)
    else $error("Stored power-management field differs from written value");

  chk_shadow_shared: assert property (@(posedge clk) disable iff (rst)
    ctl.sharedRefclk == shadowShared_r)
    else $error("Stored shared clock flag differs from written value");

  chk_l1_follows_shadow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> l1Enable == $past(shadowPm_r == link_regs_pkg::PM_L0S_L1))
    else $error("L1 enable does not follow stored field");

  chk_shared_out_follows: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> sharedRefclk == $past(shadowShared_r))
    else $error("Shared clock output does not follow stored flag");

endmodule

/* verilog/link_regs_pkg.sv */
// Constants for the upstream link control and link status registers
package link_regs_pkg;

  // Configuration-space byte offsets
  localparam logic [7:0]  LINK_CTRL_OFFSET   = 8'hA0;
  localparam logic [7:0]  LINK_STATUS_OFFSET = 8'hA2;

  // Link control field positions
  localparam int          SHARED_REFCLK_POS  = 6;
  localparam int          RETRAIN_POS        = 5;
  localparam int          LINK_OFF_POS       = 4;
  localparam int          COMPL_BOUND_POS    = 3;
  localparam int          CTRL_RSVD_POS      = 2;
  localparam int          PM_FIELD_LSB       = 0;
  localparam int          PM_FIELD_W         = 2;

  // Link control reset value and constant bits
  localparam logic [15:0] LINK_CTRL_RESET    = 16'h0000;
  localparam logic        COMPL_BOUND_64B    = 1'b0;

  // Power-management field encodings
  localparam logic [1:0]  PM_DISABLED        = 2'h0;
  localparam logic [1:0]  PM_L0S             = 2'h1;
  localparam logic [1:0]  PM_RESERVED        = 2'h2;
  localparam logic [1:0]  PM_L0S_L1          = 2'h3;

  // Link status field positions
  localparam int          STAT_RSVD_LSB      = 13;
  localparam int          SLOT_REFCLK_POS    = 12;
  localparam int          TRAINING_POS       = 11;
  localparam int          UNDEFINED_POS      = 10;
  localparam int          WIDTH_LSB          = 4;
  localparam int          SPEED_LSB          = 0;

  // Link status constant field values
  localparam logic        SLOT_REFCLK_VALUE  = 1'b1;
  localparam logic        TRAINING_VALUE     = 1'b0;
  localparam logic [5:0]  WIDTH_X1           = 6'h01;
  localparam logic [3:0]  SPEED_2G5          = 4'h1;
  localparam logic [2:0]  STAT_RSVD_VALUE    = 3'h0;

endpackage

/* verilog/link_ctrl_if.sv */
// Carrier between the register front end and the link control store
`timescale 1ns/1ps
interface link_ctrl_if;
  logic       wrLow;
  logic [7:0] wrByte;
  logic       sharedRefclk;
  logic [1:0] pmField;

  modport store (
    input  wrLow,
    input  wrByte,
    output sharedRefclk,
    output pmField
  );
  modport user (
    output wrLow,
    output wrByte,
    input  sharedRefclk,
    input  pmField
  );
endinterface

/* verilog/link_ctrl_store.sv */
// Writable fields of the link control register
`timescale 1ns/1ps
module link_ctrl_store (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Front end
  link_ctrl_if.store ctl
);

  logic       sharedRefclk_r;
  logic       sharedRefclk_nxt;
  logic [1:0] pmField_r;
  logic [1:0] pmField_nxt;

  // Only the low byte carries writable bits; the others are dropped
  always_comb begin
    sharedRefclk_nxt = sharedRefclk_r;
    pmField_nxt      = pmField_r;
    if (ctl.wrLow) begin
      sharedRefclk_nxt = ctl.wrByte[link_regs_pkg::SHARED_REFCLK_POS];
      pmField_nxt      = ctl.wrByte[link_regs_pkg::PM_FIELD_LSB +: link_regs_pkg::PM_FIELD_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sharedRefclk_r <= link_regs_pkg::LINK_CTRL_RESET[link_regs_pkg::SHARED_REFCLK_POS];
      pmField_r      <= link_regs_pkg::LINK_CTRL_RESET[link_regs_pkg::PM_FIELD_LSB +: link_regs_pkg::PM_FIELD_W];
    end else begin
      sharedRefclk_r <= sharedRefclk_nxt;
      pmField_r      <= pmField_nxt;
    end
  end

  assign ctl.sharedRefclk = sharedRefclk_r;
  assign ctl.pmField      = pmField_r;

endmodule

/* dv/cfg_sw_model.sv */
// Configuration software model driving dword config accesses
`timescale 1ns/1ps
module cfg_sw_model #(
  parameter int ADDR_W = 10
) (
  // Clock
  input  wire logic              clk,
  // Requests
  output logic                   cfgRdEn,
  output logic                   cfgWrEn,
  output logic      [ADDR_W-1:0] cfgDwAddr,
  output logic      [3:0]        cfgByteEn,
  output logic      [31:0]       cfgWrData,
  // Answers
  input  wire logic [31:0]       cfgRdData,
  input  wire logic              cfgRdValid
);
  initial begin
    cfgRdEn   = 1'b0;
    cfgWrEn   = 1'b0;
    cfgDwAddr = '0;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0000_0000;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfgWrEn   = 1'b1;
    cfgDwAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(negedge clk);
    cfgWrEn   = 1'b0;
    cfgDwAddr = ~a;
    cfgByteEn = ~be;
    cfgWrData = ~d;
  endtask

  // Write followed by a read in the very next cycle
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] d, output logic v);
    @(negedge clk);
    cfgWrEn   = 1'b1;
    cfgDwAddr = a;
    cfgByteEn = be;
    cfgWrData = wd;
    @(negedge clk);
    cfgWrEn   = 1'b0;
    cfgRdEn   = 1'b1;
    cfgByteEn = ~be;
    cfgWrData = ~wd;
    @(negedge clk);
    d         = cfgRdData & 32'hFBFF_FFFF;
    v         = cfgRdValid;
    cfgRdEn   = 1'b0;
    cfgDwAddr = ~a;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    cfgRdEn   = 1'b1;
    cfgDwAddr = a;
    @(negedge clk);
    // Status bit 10 carries no meaning, so it is masked off
    d         = cfgRdData & 32'hFBFF_FFFF;
    v         = cfgRdValid;
    cfgRdEn   = 1'b0;
    cfgDwAddr = ~a;
  endtask
endmodule

/* dv/tb.sv */
// Testbench for the upstream link control and status registers
`timescale 1ns/1ps
module tb;
  localparam logic [9:0] LINK_IDX = 10'h028;
  logic        clk;
  logic        rst;
  logic        cfgRdEn;
  logic        cfgWrEn;
  logic [9:0]  cfgDwAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData;
  logic [31:0] cfgRdData;
  logic        cfgRdValid;
  logic        sharedRefclk;
  logic        l0sEnable;
  logic        l1Enable;
  logic [31:0] rdData;
  logic        rdValid;
  logic [7:0]  wd;
  int          err_count;
  int          check_count;

  upstream_link_ctrl_status_regs #(.ADDR_W(10), .UNDEFINED_VAL(1'b1)) uut (
    .clk(clk), .rst(rst), .cfgRdEn(cfgRdEn), .cfgWrEn(cfgWrEn), .cfgDwAddr(cfgDwAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .sharedRefclk(sharedRefclk), .l0sEnable(l0sEnable), .l1Enable(l1Enable));

  cfg_sw_model #(.ADDR_W(10)) sw (
    .clk(clk), .cfgRdEn(cfgRdEn), .cfgWrEn(cfgWrEn), .cfgDwAddr(cfgDwAddr), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));

  always #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Checks a link dword answer; status is 1011h with bit 10 masked
  task automatic check_link(input logic [15:0] ctrlE, input logic [2:0] pins);
    check({31'h0, rdValid}, 32'h0000_0001);
    check(rdData, {16'h1011, ctrlE});
    check({29'h0, sharedRefclk, l0sEnable, l1Enable}, {29'h0, pins});
  endtask

  task automatic read_link(input logic [15:0] ctrlE, input logic [2:0] pins);
    sw.rd(LINK_IDX, rdData, rdValid);
    check_link(ctrlE, pins);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    read_link(16'h0000, 3'b000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wd = {1'b0, i[0], 4'h0, i[1:0]};
      sw.wr(LINK_IDX, 4'h1, {24'h0, wd});
      read_link({8'h0, wd}, {i[0], i[0], i == 3});
    end
    $display("test power and clock fields done");
    sw.wr_rd(LINK_IDX, 4'h1, 32'h0000_0000, rdData, rdValid);
    check_link(16'h0000, 3'b000);
    sw.wr_rd(LINK_IDX, 4'hF, 32'hFFFF_FFFF, rdData, rdValid);
    check_link(16'h0043, 3'b111);
    sw.wr_rd(LINK_IDX, 4'hE, 32'h0000_0000, rdData, rdValid);
    check_link(16'h0043, 3'b111);
    sw.wr(LINK_IDX + 10'h001, 4'hF, 32'h0000_0000);
    read_link(16'h0043, 3'b111);
    sw.rd(LINK_IDX + 10'h001, rdData, rdValid);
    check(rdData, 32'h0000_0000);
    $display("test read-only bits done");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    read_link(16'h0000, 3'b000);
    sw.wr(LINK_IDX, 4'h1, 32'h0000_0002);
    read_link(16'h0002, 3'b000);
    $display("test second reset done");
    test_done();
  end
endmodule
